// ==== verilog/tsm_regs.svh ====
// Offsets, field positions, reset values and timing counts of the sensor serial slave
`ifndef TSM_REGS_SVH
`define TSM_REGS_SVH
// System clock rate in Hz
`define TSM_CLK_HZ 50000000
// Bus stuck-low timeout in milliseconds, and its count of cycles
`define TSM_TOUT_MS 32
`define TSM_TOUT_CYC (`TSM_TOUT_MS * (`TSM_CLK_HZ / 1000))
// Glitch filter lengths, fast mode and high-speed mode
`define TSM_FILT_FS 3'h3
`define TSM_FILT_HS 3'h1
// Length of one conversion of both channels, in cycles
`define TSM_CONV_CYC 2048
// Register pointers
`define TSM_PTR_RST 8'h00
`define TSM_PTR_STATUS_RD 8'h02
`define TSM_PTR_CFG1_RD 8'h03
`define TSM_PTR_CFG1_WR 8'h09
`define TSM_PTR_ONESHOT 8'h0F
// Configuration register one
`define TSM_CFG1_RST 8'h00
`define TSM_CFG1_WMASK 8'hE4
`define TSM_CFG1_MASK 7
`define TSM_CFG1_SHDN 6
`define TSM_CFG1_ALSEL 5
// Status register busy flag
`define TSM_STAT_BUSY 7
// Bus addresses and codes
`define TSM_ADDR_BASE 7'h4C
`define TSM_GC_ADDR 8'h00
`define TSM_GC_RESET 8'h06
`define TSM_ARA_BYTE 8'h19
`define TSM_HS_CODE 5'h01
`endif

// ==== verilog/tsm_pkg.sv ====
// Types of the sensor serial slave
package tsm_pkg;
  // Bus byte engine states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_RX   = 3'h2,
    ST_RACK = 3'h6,
    ST_TX   = 3'h7,
    ST_TACK = 3'h5,
    ST_IGN  = 3'h4
  } tsm_bus_st_t;
  // Kind of the addressed transfer
  typedef enum logic [1:0] {
    MD_NORM = 2'h0,
    MD_GC   = 2'h1,
    MD_ARA  = 2'h2
  } tsm_mode_t;
  // Conversion sequencer states
  typedef enum logic [1:0] {
    CV_IDLE = 2'h0,
    CV_RUN  = 2'h1,
    CV_DONE = 2'h3
  } tsm_conv_st_t;
endpackage : tsm_pkg

// ==== verilog/tsm_conv_if.sv ====
// Link between the serial slave and the conversion sequencer
interface tsm_conv_if;
  logic run;        // Continuous mode, shutdown clear
  logic trig;       // One-shot pulse
  logic abort;      // Drop conversion at once
  logic supply_ok;  // Supply valid, synchronised
  logic busy;       // Conversion running
  logic done;       // Result ready pulse
  modport ctl (output run, trig, abort, supply_ok, input busy, done);
  modport seq (input run, trig, abort, supply_ok, output busy, done);
endinterface : tsm_conv_if

// ==== verilog/tsm_conv_seq.sv ====
// Conversion sequencer: continuous, one-shot and abort
`include "tsm_regs.svh"
module tsm_conv_seq #(
  parameter int CONV_CYC = `TSM_CONV_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Control link
  tsm_conv_if.seq  cif
);
  localparam int CW = $clog2(CONV_CYC);

  generate
    if (CONV_CYC < 2) begin : g_bad_len
      $error("CONV_CYC must be at least 2");
    end
  endgenerate

  tsm_pkg::tsm_conv_st_t st_reg, st_next;   // Sequencer state
  logic [CW-1:0]         cnt_reg, cnt_next; // Conversion timer
  logic                  pend_reg, pend_next; // One-shot waiting
  logic                  busy_reg, busy_next;
  logic                  done_reg, done_next;

  assign cif.busy = busy_reg;
  assign cif.done = done_reg;

  // Next state of the sequencer
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    pend_next = pend_reg;
    // (RL3) One-shot only in shutdown
    if (cif.trig && !cif.run) begin
      pend_next = 1'b1;
    end
    unique case (st_reg)
      tsm_pkg::CV_IDLE: begin
        // (RL2) Restart when continuous
        if (cif.run || pend_reg) begin
          pend_next = 1'b0;
          // (RL14) Skip on bad supply
          if (cif.supply_ok) begin
            st_next  = tsm_pkg::CV_RUN;
            cnt_next = '0;
          end
        end
      end
      tsm_pkg::CV_RUN: begin
        // (RL14) Supply lost, result dropped
        if (!cif.supply_ok) begin
          st_next = tsm_pkg::CV_IDLE;
        end else if (cnt_reg == CW'(CONV_CYC - 1)) begin
          st_next = tsm_pkg::CV_DONE;
        end else begin
          cnt_next = cnt_reg + CW'(1);
        end
      end
      tsm_pkg::CV_DONE: begin
        st_next = tsm_pkg::CV_IDLE;
      end
      default: begin
        // Illegal code, recover
        st_next = tsm_pkg::CV_IDLE;
      end
    endcase
    // (RL1) Abort wins over all
    if (cif.abort) begin
      st_next   = tsm_pkg::CV_IDLE;
      pend_next = 1'b0;
    end
    busy_next = (st_next == tsm_pkg::CV_RUN);
    done_next = (st_next == tsm_pkg::CV_DONE);
  end

  // Sequencer registers
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg   <= tsm_pkg::CV_IDLE;
      cnt_reg  <= '0;
      pend_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      pend_reg <= pend_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end
endmodule : tsm_conv_seq

// ==== verilog/tsm_serial_slave.sv ====
// Two-wire slave with shutdown, one-shot, timeout, Hs-mode, general call and alert response
// Function
// (RL1) Shutdown set aborts conversion at once
// (RL2) Shutdown clear: convert back to back
// (RL3) One-shot write in shutdown: one conversion
// (RL4) One-shot data byte is discarded
// (RL5) Master waits before first one-shot
// (RL6) Slave only, bytes MSB first
// (RL7) Fast and high-speed bus rates
// (RL8) Address plus direction, ninth clock acknowledge
// (RL9) Start and stop from SDA edges
// (RL10) Master ends read by not acknowledging
// (RL11) Fixed slave address per build variant
// (RL12) First written byte loads the pointer
// (RL13) Reads use the held pointer
// (RL14) No conversion while supply invalid
// (RL15) Lines low too long reset interface
// (RL16) Hs code: no acknowledge, fast filters off
// (RL17) General call 06h resets everything
// (RL18) Alert response returns own address
// (RL19) Address LSB tells high or low
// (RL20) After response set mask, release alert
// (RL21) Host reads status, then clears mask
// (RL22) Lost arbitration keeps alert asserted
// (RL23) Pointer resets to zero
// (RL24) Mask bit holds alert inactive
// (RL25) Unmatched addresses left unanswered
`include "tsm_regs.svh"
module tsm_serial_slave #(
  parameter bit ADDR_VARIANT = 1'b0,
  parameter int TOUT_CYC     = `TSM_TOUT_CYC,
  parameter int CONV_CYC     = `TSM_CONV_CYC
) (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  // Two-wire bus pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe_n,
  // Alert pin, open drain
  output logic            o_alert,
  output logic            o_alert_oe_n,
  // Limit logic on this clock
  input  wire logic       i_alert_cond,
  input  wire logic       i_alert_high,
  // Supply monitor pin
  input  wire logic       i_supply_ok,
  // Rest of the register map
  input  wire logic [7:0] i_ext_rdata,
  output logic      [7:0] o_reg_ptr,
  output logic      [7:0] o_wr_data,
  output logic            o_wr_stb,
  output logic            o_soft_rst,
  // Mode and conversion state
  output logic            o_hs_mode,
  output logic            o_shutdown,
  output logic            o_alarm_sel,
  output logic            o_conv_busy,
  output logic            o_conv_done
);
  localparam int TW = $clog2(TOUT_CYC + 1);
  // (RL11) Address fixed by variant
  localparam logic [6:0] OWN_ADDR = `TSM_ADDR_BASE | {6'h00, ADDR_VARIANT};

  generate
    if (TOUT_CYC < 1) begin : g_bad_tout
      $error("TOUT_CYC must be at least 1");
    end
  endgenerate

  // Read data for the current pointer
  function automatic logic [7:0] rd_byte(input logic [7:0] ptr, input logic [7:0] cfg,
                                         input logic busy, input logic [7:0] ext);
    logic [7:0] b;
    b = ext;
    if (ptr == `TSM_PTR_STATUS_RD) begin
      b[`TSM_STAT_BUSY] = busy;
    end else if (ptr == `TSM_PTR_CFG1_RD) begin
      b = cfg;
    end
    return b;
  endfunction : rd_byte

  // Input synchronisers: scl, sda, supply
  logic [2:0] pin_raw;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;

  assign pin_raw = {i_supply_ok, i_sda, i_scl};

  // Two flops per pin, first one feeds only the second
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // Glitch filters, length follows the bus speed
  logic       hs_reg, hs_next;     // High-speed filters on
  logic [1:0] filt_reg;            // Filtered {sda, scl}
  logic [1:0] filt_next;
  logic [1:0] filt_q_reg;          // Previous filtered value
  logic [2:0] fthr;                // Active filter length

  // (RL7) Filter length sets rate
  // (RL16) Shorter filter in Hs-mode
  assign fthr = hs_reg ? `TSM_FILT_HS : `TSM_FILT_FS;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      logic [2:0] fcnt_reg, fcnt_next;  // Cycles of disagreement
      // Accept a new level only once it has held long enough
      always_comb begin
        filt_next[gi] = filt_reg[gi];
        fcnt_next     = 3'h0;
        if (sync2_reg[gi] != filt_reg[gi]) begin
          if (fcnt_reg + 3'h1 >= fthr) begin
            filt_next[gi] = sync2_reg[gi];
          end else begin
            fcnt_next = fcnt_reg + 3'h1;
          end
        end
      end
      always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          filt_reg[gi]   <= 1'b1;
          filt_q_reg[gi] <= 1'b1;
          fcnt_reg       <= 3'h0;
        end else begin
          filt_reg[gi]   <= filt_next[gi];
          filt_q_reg[gi] <= filt_reg[gi];
          fcnt_reg       <= fcnt_next;
        end
      end
    end
  endgenerate

  // Bus events on filtered lines
  logic scl_f, sda_f, scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_f    = filt_reg[0];
  assign sda_f    = filt_reg[1];
  assign scl_rise = scl_f & ~filt_q_reg[0];
  assign scl_fall = ~scl_f & filt_q_reg[0];
  // (RL9) SDA edge while SCL high
  assign bus_start = scl_f & filt_q_reg[0] & filt_q_reg[1] & ~sda_f;
  assign bus_stop  = scl_f & filt_q_reg[0] & ~filt_q_reg[1] & sda_f;

  // Conversion sequencer link
  tsm_conv_if cif ();

  tsm_conv_seq #(
    .CONV_CYC (CONV_CYC)
  ) u_seq (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .cif       (cif)
  );

  // Byte engine and register state
  tsm_pkg::tsm_bus_st_t st_reg, st_next;       // Engine state
  tsm_pkg::tsm_mode_t   mode_reg, mode_next;   // Transfer kind
  logic [2:0]           cnt_reg, cnt_next;     // Bit counter
  logic                 full_reg, full_next;   // Eight bits seen
  logic [7:0]           sh_reg, sh_next;       // Shift register
  logic                 rw_reg, rw_next;       // Read transfer
  logic                 first_reg, first_next; // Pointer byte due
  logic [7:0]           ptr_reg, ptr_next;     // Register pointer
  logic [7:0]           cfg_reg, cfg_next;     // Configuration one
  logic                 sda_oe_n_reg, sda_oe_n_next; // Low pulls SDA
  logic                 al_oe_n_reg, al_oe_n_next;   // Low pulls alert
  logic [TW-1:0]        tout_reg, tout_next;   // Stuck-low timer
  logic                 wr_stb_reg, wr_stb_next;
  logic [7:0]           wr_data_reg, wr_data_next;
  logic                 srst_reg, srst_next;   // Soft reset pulse
  logic                 trig_reg, trig_next;   // One-shot pulse
  logic                 abort_reg, abort_next; // Conversion abort
  logic [7:0]           rd_now;                // Byte to send

  assign rd_now = rd_byte(ptr_reg, cfg_reg, cif.busy, i_ext_rdata);

  assign cif.run       = ~cfg_reg[`TSM_CFG1_SHDN];
  assign cif.trig      = trig_reg;
  assign cif.abort     = abort_reg;
  assign cif.supply_ok = sync2_reg[2];

  // Next values of the byte engine
  always_comb begin
    st_next       = st_reg;
    mode_next     = mode_reg;
    cnt_next      = cnt_reg;
    full_next     = full_reg;
    sh_next       = sh_reg;
    rw_next       = rw_reg;
    first_next    = first_reg;
    ptr_next      = ptr_reg;
    cfg_next      = cfg_reg;
    sda_oe_n_next = sda_oe_n_reg;
    hs_next       = hs_reg;
    wr_stb_next   = 1'b0;
    wr_data_next  = wr_data_reg;
    srst_next     = 1'b0;
    trig_next     = 1'b0;
    // (RL15) Count while a line is low
    if (st_reg != tsm_pkg::ST_IDLE && !(scl_f && sda_f)) begin
      tout_next = tout_reg + TW'(1);
    end else begin
      tout_next = '0;
    end
    if (bus_stop) begin
      // (RL16) Stop ends Hs-mode
      st_next       = tsm_pkg::ST_IDLE;
      sda_oe_n_next = 1'b1;
      hs_next       = 1'b0;
    end else if (bus_start) begin
      // Start or repeated start
      st_next       = tsm_pkg::ST_ADDR;
      cnt_next      = 3'h0;
      full_next     = 1'b0;
      first_next    = 1'b1;
      sda_oe_n_next = 1'b1;
    end else if (tout_reg == TW'(TOUT_CYC - 1)) begin
      // (RL15) Release and wait for start
      st_next       = tsm_pkg::ST_IDLE;
      sda_oe_n_next = 1'b1;
      tout_next     = '0;
    end else if (scl_rise) begin
      unique case (st_reg)
        tsm_pkg::ST_ADDR, tsm_pkg::ST_RX: begin
          // (RL6) Shift in MSB first
          sh_next   = {sh_reg[6:0], sda_f};
          cnt_next  = cnt_reg + 3'h1;
          full_next = (cnt_reg == 3'h7);
        end
        tsm_pkg::ST_TX: begin
          cnt_next  = cnt_reg + 3'h1;
          full_next = (cnt_reg == 3'h7);
          // (RL22) Lost arbitration, back off
          if (sda_oe_n_reg && !sda_f) begin
            st_next       = tsm_pkg::ST_IGN;
            sda_oe_n_next = 1'b1;
          end
        end
        tsm_pkg::ST_TACK: begin
          // (RL20) Mask after won response
          if (mode_reg == tsm_pkg::MD_ARA) begin
            cfg_next[`TSM_CFG1_MASK] = 1'b1;
            st_next = tsm_pkg::ST_IGN;
          end
          // (RL10) Master not-acknowledge ends read
          if (sda_f) begin
            st_next = tsm_pkg::ST_IGN;
          end
        end
        tsm_pkg::ST_IDLE, tsm_pkg::ST_AACK, tsm_pkg::ST_RACK, tsm_pkg::ST_IGN: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (st_reg)
        tsm_pkg::ST_ADDR: begin
          if (full_reg) begin
            st_next = tsm_pkg::ST_AACK;
            sda_oe_n_next = 1'b0;
            if (sh_reg[7:3] == `TSM_HS_CODE) begin
              // (RL16) Hs code not acknowledged
              hs_next       = 1'b1;
              st_next       = tsm_pkg::ST_IGN;
              sda_oe_n_next = 1'b1;
            end else if (sh_reg[7:1] == OWN_ADDR) begin
              // (RL8) Own address acknowledged
              rw_next   = sh_reg[0];
              mode_next = tsm_pkg::MD_NORM;
            end else if (sh_reg == `TSM_GC_ADDR) begin
              // (RL17) General call acknowledged
              rw_next   = 1'b0;
              mode_next = tsm_pkg::MD_GC;
            end else if (sh_reg == `TSM_ARA_BYTE && !al_oe_n_reg) begin
              // (RL18) Answer alert response
              rw_next   = 1'b1;
              mode_next = tsm_pkg::MD_ARA;
            end else begin
              // (RL25) Not ours, stay off
              st_next       = tsm_pkg::ST_IGN;
              sda_oe_n_next = 1'b1;
            end
          end
        end
        tsm_pkg::ST_RX: begin
          if (full_reg) begin
            st_next       = tsm_pkg::ST_RACK;
            sda_oe_n_next = 1'b0;
            if (mode_reg == tsm_pkg::MD_GC) begin
              // (RL17) Soft reset on 06h only
              if (sh_reg == `TSM_GC_RESET) begin
                srst_next = 1'b1;
                ptr_next  = `TSM_PTR_RST;
                cfg_next  = `TSM_CFG1_RST;
              end
            end else if (first_reg) begin
              // (RL12) First byte is the pointer
              ptr_next   = sh_reg;
              first_next = 1'b0;
            end else if (ptr_reg == `TSM_PTR_CFG1_WR) begin
              cfg_next = sh_reg & `TSM_CFG1_WMASK;
            end else if (ptr_reg == `TSM_PTR_ONESHOT) begin
              // (RL4) Data byte not stored
              trig_next = 1'b1;
            end else begin
              wr_stb_next  = 1'b1;
              wr_data_next = sh_reg;
            end
          end
        end
        tsm_pkg::ST_AACK, tsm_pkg::ST_RACK: begin
          cnt_next      = 3'h0;
          full_next     = 1'b0;
          sda_oe_n_next = 1'b1;
          st_next       = tsm_pkg::ST_RX;
          if (rw_reg) begin
            st_next = tsm_pkg::ST_TX;
            // (RL19) Cause bit in address LSB
            if (mode_reg == tsm_pkg::MD_ARA) begin
              sh_next = {OWN_ADDR, i_alert_high};
            end else begin
              // (RL13) Read at held pointer
              sh_next = rd_now;
            end
            sda_oe_n_next = sh_next[7];
          end
        end
        tsm_pkg::ST_TX: begin
          if (full_reg) begin
            st_next       = tsm_pkg::ST_TACK;
            sda_oe_n_next = 1'b1;
          end else begin
            // (RL6) Next bit, MSB first
            sh_next       = {sh_reg[6:0], 1'b0};
            sda_oe_n_next = sh_reg[6];
          end
        end
        tsm_pkg::ST_TACK: begin
          // Acknowledged, send another byte
          st_next       = tsm_pkg::ST_TX;
          cnt_next      = 3'h0;
          full_next     = 1'b0;
          sh_next       = rd_now;
          sda_oe_n_next = rd_now[7];
        end
        tsm_pkg::ST_IDLE, tsm_pkg::ST_IGN: begin
        end
      endcase
    end
    // (RL1) Abort when shutdown is set
    abort_next = srst_next | (cfg_next[`TSM_CFG1_SHDN] & ~cfg_reg[`TSM_CFG1_SHDN]);
    // (RL24) Mask holds alert released
    al_oe_n_next = ~(i_alert_cond & ~cfg_next[`TSM_CFG1_MASK] & ~cfg_next[`TSM_CFG1_ALSEL]);
  end

  // Byte engine registers
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg       <= tsm_pkg::ST_IDLE;
      mode_reg     <= tsm_pkg::MD_NORM;
      cnt_reg      <= 3'h0;
      full_reg     <= 1'b0;
      sh_reg       <= 8'h00;
      rw_reg       <= 1'b0;
      first_reg    <= 1'b0;
      // (RL23) Pointer starts at zero
      ptr_reg      <= `TSM_PTR_RST;
      cfg_reg      <= `TSM_CFG1_RST;
      sda_oe_n_reg <= 1'b1;
      al_oe_n_reg  <= 1'b1;
      hs_reg       <= 1'b0;
      tout_reg     <= '0;
      wr_stb_reg   <= 1'b0;
      wr_data_reg  <= 8'h00;
      srst_reg     <= 1'b0;
      trig_reg     <= 1'b0;
      abort_reg    <= 1'b0;
    end else begin
      st_reg       <= st_next;
      mode_reg     <= mode_next;
      cnt_reg      <= cnt_next;
      full_reg     <= full_next;
      sh_reg       <= sh_next;
      rw_reg       <= rw_next;
      first_reg    <= first_next;
      ptr_reg      <= ptr_next;
      cfg_reg      <= cfg_next;
      sda_oe_n_reg <= sda_oe_n_next;
      al_oe_n_reg  <= al_oe_n_next;
      hs_reg       <= hs_next;
      tout_reg     <= tout_next;
      wr_stb_reg   <= wr_stb_next;
      wr_data_reg  <= wr_data_next;
      srst_reg     <= srst_next;
      trig_reg     <= trig_next;
      abort_reg    <= abort_next;
    end
  end

  // Open-drain data levels stay low; only the enables move
  assign o_sda        = 1'b0;
  assign o_alert      = 1'b0;
  assign o_sda_oe_n   = sda_oe_n_reg;
  assign o_alert_oe_n = al_oe_n_reg;
  assign o_reg_ptr    = ptr_reg;
  assign o_wr_data    = wr_data_reg;
  assign o_wr_stb     = wr_stb_reg;
  assign o_soft_rst   = srst_reg;
  assign o_hs_mode    = hs_reg;
  assign o_shutdown   = cfg_reg[`TSM_CFG1_SHDN];
  assign o_alarm_sel  = cfg_reg[`TSM_CFG1_ALSEL];
  assign o_conv_busy  = cif.busy;
  assign o_conv_done  = cif.done;
endmodule : tsm_serial_slave

// ==== sim/tsm_bus_master.sv ====
// Two-wire bus master model for the sensor slave bench
module tsm_bus_master (
  // Master pins
  output logic      o_scl,
  output logic      o_sda_pull,
  // Resolved SDA level
  input  wire logic i_sda
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus idle, both lines high
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end
  // fall with SCL high; long lead lets the slave drop its ack first
  task automatic start();
    o_sda_pull = 1'b0;
    #200 o_scl = 1'b1;
    #80 o_sda_pull = 1'b1;
    #80 o_scl = 1'b0;
  endtask : start
  task automatic stop();
    o_sda_pull = 1'b1;
    #160 o_scl = 1'b1;
    #80 o_sda_pull = 1'b0;
    #80;
  endtask : stop
  // one 260 ns bit; long low phase covers the slave's output lag
  task automatic bit_io(input logic b, output logic r);
    #20 o_sda_pull = ~b;
    #160 o_scl = 1'b1;
    #80 r = i_sda;
    o_scl = 1'b0;
  endtask : bit_io
  // address, pointer or data byte, MSB first
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask : rbyte
endmodule : tsm_bus_master

// ==== sim/tsm_serial_slave_chk.sv ====
// Port checker of the two-wire sensor slave
module tsm_serial_slave_chk #(
  parameter int TOUT_CYC = 200
) (
  input wire logic       i_sys_clk,
  input wire logic       i_nrst,
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic       i_supply_ok,
  input wire logic       i_alert_cond,
  input wire logic       o_sda_oe_n,
  input wire logic       o_alert_oe_n,
  input wire logic [7:0] o_reg_ptr,
  input wire logic       o_wr_stb,
  input wire logic       o_soft_rst,
  input wire logic       o_hs_mode,
  input wire logic       o_shutdown,
  input wire logic       o_conv_busy,
  input wire logic       o_conv_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int low_reg;  // Cycles SCL has stayed low
  int low_next; // Next count
  // Count a stuck-low clock line
  always_comb begin
    low_next = i_scl ? 0 : low_reg + 1;
  end
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) low_reg <= 0;
    else low_reg <= low_next;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  a_shdn_abort: assert property ($rose(o_shutdown) |-> ##[0:3] !o_conv_busy)
    else $error("conversion kept running into shutdown");
  a_cont_next: assert property (o_conv_done && !o_shutdown && i_supply_ok && $past(i_supply_ok, 3)
    |-> ##[1:4] o_conv_busy)
    else $error("no new conversion after done");
  a_oneshot_once: assert property (o_conv_done && o_shutdown |=> !o_conv_busy [*8])
    else $error("conversion restarted in shutdown");
  a_trig_discard: assert property (o_wr_stb |-> o_reg_ptr != 8'h0F)
    else $error("one-shot byte passed on as a write");
  a_no_supply: assert property (!i_supply_ok [*4] |-> !$rose(o_conv_busy))
    else $error("conversion started without supply");
  a_tout_free: assert property (low_reg > TOUT_CYC + 16 |-> o_sda_oe_n)
    else $error("SDA still held after bus timeout");
  a_hs_end: assert property (o_hs_mode && i_scl && $rose(i_sda) |-> ##[1:12] !o_hs_mode)
    else $error("high-speed filters kept after stop");
  a_gc_reset: assert property (o_soft_rst |-> ##[0:2] (o_reg_ptr == 8'h00 && !o_shutdown))
    else $error("soft reset left state behind");
  a_alert_cause: assert property (!o_alert_oe_n |-> $past(i_alert_cond))
    else $error("alert driven without a condition");
endmodule : tsm_serial_slave_chk

// ==== sim/tsm_serial_slave_tb.sv ====
// Self-checking bench of the two-wire sensor slave
module tsm_serial_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TOUT = 400; // Shortened stuck-bus timeout
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic alert_cond = 1'b0;
  logic supply_ok = 1'b1;
  logic alert_high = 1'b1;
  int n_dn = 0;
  int n_wr = 0;
  logic [7:0] d;
  int n;
  int miscompares = 0;
  int num_checks = 0;
  wire logic scl, pull, sda_oe_n, alert_oe_n, hs_mode, shutdown, conv_done, wr_stb, alarm_sel;
  wire logic [7:0] reg_ptr, wr_data;
  // Open-drain SDA with pull-up
  wire logic sda = ~pull & sda_oe_n;
  always #10 i_sys_clk = ~i_sys_clk;
  // Pulse counters, read before the edge moves them
  always @(posedge i_sys_clk) begin
    n_dn += conv_done;
    n_wr += wr_stb;
  end
  tsm_bus_master m (.o_scl(scl), .o_sda_pull(pull), .i_sda(sda));
  tsm_serial_slave #(.TOUT_CYC(TOUT), .CONV_CYC(20)) dut (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda), .o_sda(), .o_sda_oe_n(sda_oe_n),
    .o_alert(), .o_alert_oe_n(alert_oe_n), .i_alert_cond(alert_cond), .i_alert_high(alert_high),
    .i_supply_ok(supply_ok), .i_ext_rdata(8'h5A), .o_reg_ptr(reg_ptr), .o_wr_data(wr_data), .o_wr_stb(wr_stb),
    .o_soft_rst(), .o_hs_mode(hs_mode), .o_shutdown(shutdown), .o_alarm_sel(alarm_sel), .o_conv_busy(),
    .o_conv_done(conv_done));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge i_sys_clk);
    #2;
  endtask : tick
  task automatic cnt(input int c);
    n = 0;
    repeat (c) begin
      tick(1);
      n += conv_done;
    end
  endtask : cnt
  task automatic wb(input logic [7:0] b, input logic e);
    logic a;
    m.wbyte(b, a);
    chk(a, e);
  endtask : wb
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    m.start();
    wb(8'h98, 1'b1);
    wb(p, 1'b1);
    wb(v, 1'b1);
    m.stop();
  endtask : wr
  task automatic rd(input logic [7:0] p, input logic [7:0] e, input logic np);
    m.start();
    if (!np) begin
      wb(8'h98, 1'b1);
      wb(p, 1'b1);
      m.start();
    end
    wb(8'h99, 1'b1);
    m.rbyte(1'b1, d);
    chk(d, e);
    m.stop();
  endtask : rd
  task automatic ara(input logic [7:0] e);
    m.start();
    wb(8'h19, 1'b1);
    m.rbyte(1'b1, d);
    chk(d, e);
    m.stop();
  endtask : ara
  task automatic test_done();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // Main sequence
  initial begin
    tick(4);
    i_nrst = 1'b1;
    tick(6);
    chk(reg_ptr, 8'h00);
    rd(8'h00, 8'h5A, 1'b1);
    cnt(200);
    chk(n >= 8, 1'b1);
    $display("test reset done");
    wr(8'h0B, 8'h55);
    chk(reg_ptr, 8'h0B);
    chk(wr_data, 8'h55);
    chk(8'(n_wr), 8'h01);
    wr(8'h09, 8'h40);
    chk(shutdown, 1'b1);
    cnt(100);
    chk(8'(n), 8'h00);
    rd(8'h03, 8'h40, 1'b0);
    rd(8'h03, 8'h40, 1'b1);
    n = n_dn;
    wr(8'h0F, 8'hA5);
    tick(100);
    chk(8'(n_dn - n), 8'h01);
    chk(8'(n_wr), 8'h01);
    rd(8'h03, 8'h40, 1'b0);
    $display("test one-shot done");
    m.start();
    wb(8'h9A, 1'b0);
    m.start();
    wb(8'h08, 1'b0);
    chk(hs_mode, 1'b1);
    m.stop();
    tick(10);
    chk(hs_mode, 1'b0);
    m.start();
    wb(8'h99, 1'b1);
    tick(12);
    chk(sda_oe_n, 1'b0);
    tick(TOUT + 20);
    chk(sda_oe_n, 1'b1);
    m.stop();
    $display("test bus faults done");
    tick(1);
    alert_cond = 1'b1;
    tick(4);
    chk(alert_oe_n, 1'b0);
    ara(8'h99);
    chk(alert_oe_n, 1'b1);
    rd(8'h03, 8'hC0, 1'b0);
    rd(8'h02, 8'h5A, 1'b0);
    wr(8'h09, 8'h40);
    tick(4);
    chk(alert_oe_n, 1'b0);
    alert_high = 1'b0;
    ara(8'h98);
    chk(alert_oe_n, 1'b1);
    alert_cond = 1'b0;
    $display("test alert done");
    wr(8'h09, 8'h64);
    chk(alarm_sel, 1'b1);
    m.start();
    wb(8'h00, 1'b1);
    wb(8'h06, 1'b1);
    m.stop();
    chk(shutdown, 1'b0);
    chk(reg_ptr, 8'h00);
    chk(alarm_sel, 1'b0);
    tick(1);
    supply_ok = 1'b0;
    tick(10);
    cnt(100);
    chk(8'(n), 8'h00);
    supply_ok = 1'b1;
    cnt(100);
    chk(n >= 3, 1'b1);
    $display("test reset and supply done");
    test_done();
  end
  // Watchdog against a hung bus
  initial begin
    #400000;
    miscompares++;
    test_done();
  end
endmodule : tsm_serial_slave_tb
bind tsm_serial_slave tsm_serial_slave_chk #(.TOUT_CYC(TOUT_CYC)) u_chk (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_scl(i_scl), .i_sda(i_sda), .i_supply_ok(i_supply_ok),
  .i_alert_cond(i_alert_cond), .o_sda_oe_n(o_sda_oe_n), .o_alert_oe_n(o_alert_oe_n),
  .o_reg_ptr(o_reg_ptr), .o_wr_stb(o_wr_stb), .o_soft_rst(o_soft_rst), .o_hs_mode(o_hs_mode),
  .o_shutdown(o_shutdown), .o_conv_busy(o_conv_busy), .o_conv_done(o_conv_done));
